//--- ees_cfg.svh
`ifndef EES_CFG_SVH
`define EES_CFG_SVH

// ==========================================================
// Array organisation
`define EES_MEM_WORDS 1024
`define EES_FIFO_DEPTH 16
`define EES_PAGE_BITS 4

// ==========================================================
// Serial frame layout
`define EES_DEV_TYPE 4'hA
`define EES_LAST_BIT 4'h7
`define EES_ACK_SLOT 4'h8

// ==========================================================
// Reset values of the pin samplers: bit0 clock, bit1 data idle high
`define EES_SYNC_RST 5'h03

`endif

//--- ees_pkg.sv
`default_nettype none

// ==========================================================
// Types shared by the serial slave
package ees_pkg;

  // Transfer phase of the slave
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DEV   = 3'b001,
    ST_WADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_READ  = 3'b100
  } ees_state_t;

endpackage : ees_pkg

`default_nettype wire

//--- ees_fifo.sv
`default_nettype none

// ==========================================================
// Parameterised FIFO with valid/ready on both sides
module ees_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Fill side
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  // Drain side
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);

  localparam int PW = $clog2(DEPTH);

  // Pointer arithmetic needs a power of two of at least two
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("ees_fifo: DEPTH must be a power of two, 2 or more");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW:0] wp_r;
  logic [PW:0] rp_r;
  wire full = (wp_r[PW] != rp_r[PW]) && (wp_r[PW-1:0] == rp_r[PW-1:0]);
  wire empty = (wp_r == rp_r);
  wire push = i_wr_valid && !full;
  wire pop = i_rd_ready && !empty;

  // Handshakes; read data comes straight from the storage flops
  assign o_wr_ready = !full;
  assign o_rd_valid = !empty;
  assign o_rd_data = mem_r[rp_r[PW-1:0]];

  // Pointers; the extra top bit tells full from empty
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
    end
  end

  // Storage has no reset, so it maps onto plain RAM
  always_ff @(posedge i_clock) begin
    if (push) mem_r[wp_r[PW-1:0]] <= i_wr_data;
  end

  chk_fifo_full_stall : // back-pressure
    assert property (@(posedge i_clock) disable iff (i_rst)
      (full && !pop) |=> (!o_wr_ready && wp_r == $past(wp_r)))
    else $error("fifo accepted a word while full");

endmodule // ees_fifo

`default_nettype wire

//--- ees_link.sv
`default_nettype none
`include "ees_cfg.svh"

// ==========================================================
// Two-wire serial EEPROM slave: pin edges, selection, lock
module ees_link import ees_pkg::*; #(
  parameter int MEM_WORDS = `EES_MEM_WORDS,
  parameter int FIFO_DEPTH = `EES_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST,
  // Two-wire bus pins
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA_OUT,
  output logic O_SDA_OE,
  // Straps and array lock
  input wire logic I_CHIP_SELECT_STRAP_LOW,
  input wire logic I_CHIP_SELECT_STRAP_HIGH,
  input wire logic I_ARRAY_LOCK,
  // Status
  output logic O_BUSY
);

  localparam int AW = $clog2(MEM_WORDS);
  localparam int BW = AW - 8;
  localparam int FW = AW + 8;
  localparam int PB = `EES_PAGE_BITS;

  // Only the two array sizes have a selection byte layout
  if (MEM_WORDS != 512 && MEM_WORDS != 1024) begin : g_bad_size
    $error("ees_link: MEM_WORDS must be 512 or 1024");
  end
  if (FIFO_DEPTH < (1 << PB)) begin : g_bad_fifo
    $error("ees_link: FIFO_DEPTH must hold one page");
  end

  // ========================================================
  // Pin synchronisers and edge finders
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic scl_q_r;
  logic sda_q_r;
  wire [4:0] pins = {I_CHIP_SELECT_STRAP_HIGH, I_CHIP_SELECT_STRAP_LOW,
                     I_ARRAY_LOCK, I_SDA, I_SCL};

  // Clock and data samples start high so release of reset shows no false edge
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      meta_r <= `EES_SYNC_RST;
      sync_r <= `EES_SYNC_RST;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
      scl_q_r <= sync_r[0];
      sda_q_r <= sync_r[1];
    end
  end

  // Named views of the synchronised pins
  wire scl = sync_r[0];
  wire sda = sync_r[1];
  // A floating lock pin is pulled to ground at the pad
  wire lock_on = (sync_r[2] == 1'b1);
  wire strap_lo = sync_r[3];
  wire strap_hi = sync_r[4];

  // Bus events; start and stop need the clock high on both samples
  wire scl_rise = scl && !scl_q_r;
  wire scl_fall = !scl && scl_q_r;
  wire bus_start = scl && scl_q_r && sda_q_r && !sda;
  wire bus_stop = scl && scl_q_r && !sda_q_r && sda;

  // ========================================================
  // Bit engine state
  ees_state_t state_r;
  ees_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic ack_r;
  logic ack_nxt;
  logic oe_r;
  logic [AW-1:0] addr_r;
  logic [AW-1:0] addr_nxt;
  logic busy_r;
  logic lock_commit_r;
  logic [7:0] rd_r;
  logic [7:0] mem_r [MEM_WORDS];

  // Byte assembly; the eighth rise completes a byte
  wire [7:0] byte_in = {sh_r[6:0], sda};
  wire byte_done = scl_rise && (cnt_r == `EES_LAST_BIT);
  wire ack_rise = scl_rise && (cnt_r == `EES_ACK_SLOT);

  // Selection decode; the larger array gives up the low strap
  wire type_ok = (byte_in[7:4] == `EES_DEV_TYPE);
  wire strap_ok = (BW == 1) ? (byte_in[3:2] == {strap_hi, strap_lo})
                            : (byte_in[3] == strap_hi);
  wire dev_match = type_ok && strap_ok;
  wire [BW-1:0] blk = byte_in[BW:1];
  wire [AW-1:0] page_inc = {addr_r[AW-1:PB], addr_r[PB-1:0] + 1'b1};

  // ========================================================
  // Write staging FIFO and array commit
  wire push_valid = byte_done && (state_r == ST_WDATA);
  wire push_rdy;
  wire pop_valid;
  wire [FW-1:0] pop_data;
  wire pop_fire = pop_valid && busy_r;
  wire mem_we = pop_fire && !lock_commit_r;
  wire commit = bus_stop && pop_valid && !busy_r;

  ees_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_stage (
    .i_clock(I_CLOCK),
    .i_rst(I_RST),
    .i_wr_valid(push_valid),
    .o_wr_ready(push_rdy),
    .i_wr_data({addr_r, byte_in}),
    .o_rd_valid(pop_valid),
    .i_rd_ready(busy_r),
    .o_rd_data(pop_data)
  );

  // Phase and answer for each completed byte
  always_comb begin
    state_nxt = state_r;
    ack_nxt = ack_r;
    addr_nxt = addr_r;
    if (bus_start) begin
      state_nxt = ST_DEV;
      ack_nxt = 1'b0;
    end else if (bus_stop) begin
      state_nxt = ST_IDLE;
      ack_nxt = 1'b0;
    end else if (byte_done) begin
      unique case (state_r)
        ST_DEV: begin
          // Busy committing: stay silent so the master polls again
          ack_nxt = dev_match && !busy_r;
          if (!(dev_match && !busy_r)) begin
            state_nxt = ST_IDLE;
          end else if (byte_in[0]) begin
            state_nxt = ST_READ;
          end else begin
            state_nxt = ST_WADDR;
            addr_nxt[AW-1:8] = blk;
          end
        end
        ST_WADDR: begin
          ack_nxt = 1'b1;
          addr_nxt[7:0] = byte_in;
          state_nxt = ST_WDATA;
        end
        ST_WDATA: begin
          // A full stage refuses the byte with a missing answer
          ack_nxt = push_rdy;
          if (push_rdy) addr_nxt = page_inc;
        end
        ST_READ: ack_nxt = 1'b0;
        ST_IDLE: ack_nxt = 1'b0;
        default: begin
          state_nxt = ST_IDLE;
          ack_nxt = 1'b0;
        end
      endcase
    end else if (ack_rise && state_r == ST_READ && !ack_r) begin
      // Our own ack on the selection byte is not a master answer
      if (sda) state_nxt = ST_IDLE;
      else addr_nxt = addr_r + 1'b1;
    end
  end

  // Phase registers and the shift register
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      state_r <= ST_IDLE;
      ack_r <= 1'b0;
      addr_r <= '0;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      ack_r <= ack_nxt;
      addr_r <= addr_nxt;
      if (bus_start) cnt_r <= 4'h0;
      else if (scl_rise) cnt_r <= ack_rise ? 4'h0 : cnt_r + 4'h1;
      if (scl_rise) sh_r <= byte_in;
    end
  end

  // Data pin: only pulled low or released, moved on falls only
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      oe_r <= 1'b0;
    end else if (scl_fall) begin
      if (cnt_r == `EES_ACK_SLOT) oe_r <= ack_r;
      else oe_r <= (state_r == ST_READ) && !rd_r[~cnt_r[2:0]];
    end
  end

  assign O_SDA_OUT = 1'b0;
  assign O_SDA_OE = oe_r;
  assign O_BUSY = busy_r;

  // Commit: the lock level is caught once, at the stop
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      busy_r <= 1'b0;
      lock_commit_r <= 1'b0;
    end else if (commit) begin
      busy_r <= 1'b1;
      lock_commit_r <= lock_on;
    end else if (busy_r && !pop_valid) begin
      busy_r <= 1'b0;
    end
  end

  // Array; a locked commit still drains the stage, leaving cells alone
  always_ff @(posedge I_CLOCK) begin
    if (mem_we) mem_r[pop_data[FW-1:8]] <= pop_data[7:0];
    rd_r <= mem_r[addr_r];
  end

  // ========================================================
  // Checks
  chk_rise_capture :
    assert property (@(posedge I_CLOCK) disable iff (I_RST)
      $changed(sh_r) |-> $past(scl_rise))
    else $error("shift register moved without a clock rise");

  chk_fall_launch :
    assert property (@(posedge I_CLOCK) disable iff (I_RST)
      $changed(oe_r) |-> $past(scl_fall))
    else $error("data pin changed without a clock fall");

  chk_pin_open_drain :
    assert property (@(posedge I_CLOCK) disable iff (I_RST)
      O_SDA_OE |-> (O_SDA_OUT == 1'b0))
    else $error("data pin driven high");

  chk_lock_blocks :
    assert property (@(posedge I_CLOCK) disable iff (I_RST)
      (pop_fire && lock_commit_r) |-> !mem_we)
    else $error("locked commit changed the array");

  chk_unlock_writes :
    assert property (@(posedge I_CLOCK) disable iff (I_RST)
      (pop_fire && !lock_commit_r) |-> mem_we)
    else $error("unlocked commit dropped a byte");

  chk_lock_commit :
    assert property (@(posedge I_CLOCK) disable iff (I_RST)
      $rose(busy_r) |-> (lock_commit_r == $past(lock_on)))
    else $error("lock level not taken at commit");

  chk_dev_select :
    assert property (@(posedge I_CLOCK) disable iff (I_RST)
      (state_r == ST_DEV && byte_done && !dev_match)
        |=> (!ack_r && state_r == ST_IDLE))
    else $error("answered a foreign selection");

  chk_busy_silent :
    assert property (@(posedge I_CLOCK) disable iff (I_RST)
      (state_r == ST_DEV && byte_done && busy_r) |=> !ack_r)
    else $error("answered while committing");

  chk_page_wrap :
    assert property (@(posedge I_CLOCK) disable iff (I_RST)
      (push_valid && push_rdy)
        |=> (addr_r[AW-1:PB] == $past(addr_r[AW-1:PB])))
    else $error("write address left its page");

  chk_drain_bound :
    assert property (@(posedge I_CLOCK) disable iff (I_RST)
      $rose(busy_r) |-> ##[1:17] !busy_r)
    else $error("commit did not finish");

endmodule // ees_link

`default_nettype wire

//--- ees_bus_master.sv
`default_nettype none

// ==========================================================
// Two-wire bus master model, open drain data, clock driven high and low by the master
module ees_bus_master (
  // Clock
  input wire logic i_clock,
  // Bus pins
  input wire logic i_sda_wire,
  output logic o_scl,
  output logic o_sda,
  // Byte seen on the wire, ack slot in bit 0
  output logic o_res_v,
  output logic [8:0] o_res
);
  timeunit 1ns;
  timeprecision 1ps;

  // Clock and data rest high between frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    o_res_v = 1'b0;
    o_res = '0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  // Start or repeated start; the clock ends low
  task automatic start();
    tick(2);
    o_sda = 1'b1;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    o_sda = 1'b0;
    tick(4);
    o_scl = 1'b0;
  endtask

  // Stop, then the clock stays high while idle
  task automatic stop();
    tick(2);
    o_sda = 1'b0;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    o_sda = 1'b1;
    tick(4);
  endtask

  // Data moves only mid-low, so it is stable at the rising edge
  task automatic bit_x(input logic b, output logic r);
    tick(2);
    o_sda = b;
    tick(2);
    o_scl = 1'b1;
    tick(3);
    r = i_sda_wire;
    tick(1);
    o_scl = 1'b0;
  endtask

  // Eight bits MSB first, then the ack slot
  task automatic xfer(input logic [7:0] d, input logic mack);
    logic [8:0] s;
    logic [8:0] r;
    s = {d, mack};
    for (int i = 8; i >= 0; i--) begin
      bit_x(s[i], r[i]);
    end
    o_res = r;
    o_res_v = 1'b1;
    tick(1);
    o_res_v = 1'b0;
  endtask
endmodule // ees_bus_master

`default_nettype wire

//--- tb_top.sv
`default_nettype none
`include "ees_cfg.svh"

// ==========================================================
// Testbench for the serial EEPROM slave
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic lock = 1'b0;
  logic st_lo = 1'b0;
  logic st_hi = 1'b1;
  logic scl, m_sda, sda_oe, sda_out, busy, res_v;
  logic sda_wire;
  logic [8:0] res;
  logic [8:0] exp_q[$];
  logic [7:0] mem [0:`EES_MEM_WORDS-1];
  logic [9:0] a;
  int n_fail = 0;
  int samples_checked = 0;

  always #10 clk = ~clk;

  // Pull-up wire: low when either party pulls it
  assign sda_wire = m_sda & (~sda_oe | sda_out);

  ees_link ees_link_inst (
    .I_CLOCK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda_wire),
    .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe),
    .I_CHIP_SELECT_STRAP_LOW(st_lo), .I_CHIP_SELECT_STRAP_HIGH(st_hi),
    .I_ARRAY_LOCK(lock), .O_BUSY(busy));

  ees_bus_master ees_bus_master_inst (
    .i_clock(clk), .i_sda_wire(sda_wire), .o_scl(scl), .o_sda(m_sda),
    .o_res_v(res_v), .o_res(res));

  // Compare each byte seen on the wire with the oldest note
  always @(posedge res_v) begin
    logic [8:0] e;
    e = exp_q.pop_front();
    samples_checked++;
    if (res !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, res, e);
    end
  end

  task automatic wrap_up();
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic [7:0] sb(input logic [9:0] ad, input logic rw);
    return {`EES_DEV_TYPE, st_hi, ad[9:8], rw};
  endfunction

  // Master sends a byte; ack says whether the device should pull low
  task automatic wb(input logic [7:0] d, input logic ack);
    exp_q.push_back({d, ~ack});
    ees_bus_master_inst.xfer(d, 1'b1);
  endtask

  // Master reads a byte and answers with mack
  task automatic rb(input logic [7:0] e, input logic mack);
    exp_q.push_back({e, mack});
    ees_bus_master_inst.xfer(8'hFF, mack);
  endtask

  // Page write of n bytes; lock level is applied just before stop
  task automatic wr(input logic [9:0] ad, input int n, input logic lk);
    logic [7:0] d;
    ees_bus_master_inst.start();
    wb(sb(ad, 1'b0), 1'b1);
    wb(ad[7:0], 1'b1);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      wb(d, i < 16);
      if (!lk && i < 16) mem[{ad[9:4], 4'(ad[3:0] + i)}] = d;
    end
    lock = lk;
    ees_bus_master_inst.stop();
    // Staged bytes must be committing right after the stop
    samples_checked++;
    if (busy !== 1'b1) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, busy, 1'b1);
    end
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk);
    // A commit that never ends counts as a mismatch
    if (busy !== 1'b0) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, busy, 1'b0);
    end
    lock = 1'b0;
  endtask

  // Random read of n bytes, the last one answered with no ack
  task automatic rd(input logic [9:0] ad, input int n);
    ees_bus_master_inst.start();
    wb(sb(ad, 1'b0), 1'b1);
    wb(ad[7:0], 1'b1);
    ees_bus_master_inst.start();
    wb(sb(ad, 1'b1), 1'b1);
    for (int i = 0; i < n; i++) rb(mem[10'(ad + i)], i == n - 1);
    ees_bus_master_inst.stop();
  endtask

  // Main sequence
  initial begin
    void'($urandom(20629));
    st_hi = 1'($urandom);
    st_lo = 1'($urandom);
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    ees_bus_master_inst.start();
    wb({`EES_DEV_TYPE, ~st_hi, 3'h0}, 1'b0);
    ees_bus_master_inst.stop();
    wr(10'h3FE, 2, 1'b0);
    wr(10'h000, 1, 1'b0);
    rd(10'h3FE, 3);
    a = 10'($urandom);
    wr({a[9:4], 4'h0}, 17, 1'b0);
    wr(a, 5, 1'b0);
    rd({a[9:4], 4'h0}, 16);
    wr(a, 5, 1'b1);
    rd({a[9:4], 4'h0}, 16);
    wrap_up();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #1ms;
    n_fail++;
    wrap_up();
  end
endmodule // tb_top

`default_nettype wire
